// *** dpvdc_pkg.sv ***
package dpvdc_pkg;
    localparam logic [7:0] DPVDC_OFF_CTRL = 8'h00;
    localparam logic [7:0] DPVDC_OFF_ADDR = 8'h04;
    localparam logic [7:0] DPVDC_OFF_WDATA = 8'h08;
    localparam logic [7:0] DPVDC_OFF_STATUS = 8'h0c;
    localparam logic [7:0] DPVDC_OFF_SERIAL = 8'h10;
    localparam logic [7:0] DPVDC_OFF_SDATA = 8'h14;
    localparam int DPVDC_CTRL_GO_BIT = 8;
    localparam int DPVDC_CTRL_MASKED_BIT = 4;
    localparam int DPVDC_CTRL_LO_BIT = 5;
    localparam int DPVDC_CTRL_HI_BIT = 6;
    localparam int DPVDC_CTRL_KEEP_BIT = 7;
    localparam int DPVDC_ADDR_COL_LSB = 16;
    localparam int DPVDC_WDATA_MASK_LSB = 8;
    localparam int DPVDC_SER_GATE_BIT = 16;
    localparam int DPVDC_SER_DATA_LSB = 24;
    localparam int DPVDC_ROW_BITS = 9;
    localparam int DPVDC_PHASE_CYC = 2;
    localparam int DPVDC_SER_HALF_CYC = 2;
    localparam logic [31:0] DPVDC_RST_DATA = 32'h0000_0000;

    typedef enum logic [3:0] {
        DPVDC_OP_READ = 4'h0, DPVDC_OP_WRITE = 4'h1, DPVDC_OP_BLOCK_FILL = 4'h2,
        DPVDC_OP_ROW_FILL = 4'h3, DPVDC_OP_MASK_LOAD = 4'h4, DPVDC_OP_COLOR_LOAD = 4'h5,
        DPVDC_OP_FULL_READ_LOAD = 4'h6, DPVDC_OP_HALF_READ_LOAD = 4'h7,
        DPVDC_OP_ARRAY_LOAD = 4'h8, DPVDC_OP_HALF_ARRAY_LOAD = 4'h9,
        DPVDC_OP_ROW_ONLY_REFRESH = 4'ha, DPVDC_OP_REFRESH_OPTION_CLEAR = 4'hb,
        DPVDC_OP_REFRESH_STOP_SET = 4'hc, DPVDC_OP_REFRESH_KEEP_OPTIONS = 4'hd,
        DPVDC_OP_HIDDEN_REFRESH = 4'he, DPVDC_OP_NONE = 4'hf
    } dpvdc_op_e;

    typedef enum logic [7:0] {
        DPVDC_ST_IDLE = 8'h01, DPVDC_ST_ROW = 8'h02, DPVDC_ST_RASL = 8'h04,
        DPVDC_ST_COL = 8'h08, DPVDC_ST_CASL = 8'h10, DPVDC_ST_HIDE_UP = 8'h20,
        DPVDC_ST_HIDE_DN = 8'h40, DPVDC_ST_PRE = 8'h80
    } dpvdc_state_e;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic [DPVDC_ROW_BITS-1:0] addr;
        logic lower_write_mode_strobe_n;
        logic upper_write_mode_strobe_n;
        logic transfer_output_enable_n;
        logic special_function_select;
        logic [7:0] dq_o;
        logic dq_oe;
    } dpvdc_ram_pins_s;

    typedef struct packed {
        logic serial_clock;
        logic shift_output_gate_n;
        logic [7:0] sdq_o;
        logic sdq_oe;
    } dpvdc_ser_pins_s;
endpackage

// *** dpvdc_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Serial port clocks only while its count is nonzero, and is held while an array-buffer transfer is in progress.
// - Row bits stand at falling row strobe, column bits at falling column strobe.
// - Function select is driven at both row and column strobe edges.
// - Column-first refresh, strobe low, select high loads the stop point.
module dpvdc_ctrl #(
    parameter int PHASE_CYC = dpvdc_pkg::DPVDC_PHASE_CYC,
    parameter int SER_HALF_CYC = dpvdc_pkg::DPVDC_SER_HALF_CYC
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output dpvdc_pkg::dpvdc_ram_pins_s ram_pins_out,
    input wire logic [7:0] ram_data_pins_in,
    output dpvdc_pkg::dpvdc_ser_pins_s ser_pins_out,
    input wire logic [7:0] serial_data_pins_in
);
    typedef struct packed {
        dpvdc_pkg::dpvdc_state_e st;
        logic [7:0] cnt;
        dpvdc_pkg::dpvdc_op_e op;
        logic masked;
        logic lo_en;
        logic hi_en;
        logic keep_opt;
        logic [8:0] row;
        logic [8:0] col;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic [7:0] rdata;
        logic sdir_host;
        logic [9:0] ser_cnt;
        logic [7:0] ser_half;
        logic [7:0] sin;
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        logic [7:0] sq_s1;
        logic [7:0] sq_s2;
        dpvdc_pkg::dpvdc_ram_pins_s rp;
        dpvdc_pkg::dpvdc_ser_pins_s sp;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dpvdc_ctrl_s;

    dpvdc_ctrl_s s_reg;
    dpvdc_ctrl_s s_next;

    function automatic logic is_xfer(input dpvdc_pkg::dpvdc_op_e op);
        return op inside {dpvdc_pkg::DPVDC_OP_FULL_READ_LOAD, dpvdc_pkg::DPVDC_OP_HALF_READ_LOAD,
            dpvdc_pkg::DPVDC_OP_ARRAY_LOAD, dpvdc_pkg::DPVDC_OP_HALF_ARRAY_LOAD};
    endfunction

    function automatic logic is_cbr(input dpvdc_pkg::dpvdc_op_e op);
        return op inside {dpvdc_pkg::DPVDC_OP_REFRESH_OPTION_CLEAR,
            dpvdc_pkg::DPVDC_OP_REFRESH_STOP_SET, dpvdc_pkg::DPVDC_OP_REFRESH_KEEP_OPTIONS};
    endfunction

    function automatic logic is_wr(input dpvdc_pkg::dpvdc_op_e op);
        return op inside {dpvdc_pkg::DPVDC_OP_WRITE, dpvdc_pkg::DPVDC_OP_BLOCK_FILL,
            dpvdc_pkg::DPVDC_OP_ROW_FILL, dpvdc_pkg::DPVDC_OP_MASK_LOAD,
            dpvdc_pkg::DPVDC_OP_COLOR_LOAD};
    endfunction

    // Function select level at the falling row strobe
    function automatic logic dsf_ras(input dpvdc_pkg::dpvdc_op_e op);
        return op inside {dpvdc_pkg::DPVDC_OP_ROW_FILL, dpvdc_pkg::DPVDC_OP_MASK_LOAD,
            dpvdc_pkg::DPVDC_OP_COLOR_LOAD, dpvdc_pkg::DPVDC_OP_HALF_READ_LOAD,
            dpvdc_pkg::DPVDC_OP_HALF_ARRAY_LOAD, dpvdc_pkg::DPVDC_OP_REFRESH_STOP_SET,
            dpvdc_pkg::DPVDC_OP_REFRESH_KEEP_OPTIONS};
    endfunction

    // Write mode strobe low at the falling row strobe
    function automatic logic wm_low(input dpvdc_pkg::dpvdc_op_e op, input logic masked);
        return op inside {dpvdc_pkg::DPVDC_OP_ROW_FILL, dpvdc_pkg::DPVDC_OP_ARRAY_LOAD,
            dpvdc_pkg::DPVDC_OP_HALF_ARRAY_LOAD, dpvdc_pkg::DPVDC_OP_REFRESH_STOP_SET}
            || (masked && op inside {dpvdc_pkg::DPVDC_OP_WRITE, dpvdc_pkg::DPVDC_OP_BLOCK_FILL});
    endfunction

    localparam logic [7:0] PH_LAST = 8'(PHASE_CYC - 1);
    localparam logic [7:0] SH_LAST = 8'(SER_HALF_CYC - 1);

    logic acc;
    logic ph_done;
    assign acc = psel_in && !penable_in;
    assign ph_done = s_reg.cnt == PH_LAST;

    always_comb begin
        s_next = s_reg;
        s_next.dq_s1 = ram_data_pins_in;
        s_next.dq_s2 = s_reg.dq_s1;
        s_next.sq_s1 = serial_data_pins_in;
        s_next.sq_s2 = s_reg.sq_s1;
        s_next.cnt = ph_done ? 8'h00 : s_reg.cnt + 8'h01;
        // Register bus: answer in the first access cycle
        s_next.pready = acc;
        s_next.pslverr = 1'b0;
        s_next.prdata = 32'h0000_0000;
        if (acc) begin
            case (paddr_in)
                dpvdc_pkg::DPVDC_OFF_CTRL: s_next.prdata = {24'h000000, s_reg.keep_opt,
                    s_reg.hi_en, s_reg.lo_en, s_reg.masked, s_reg.op};
                dpvdc_pkg::DPVDC_OFF_ADDR: s_next.prdata = {7'h00, s_reg.col, 7'h00, s_reg.row};
                dpvdc_pkg::DPVDC_OFF_WDATA: s_next.prdata = {16'h0000, s_reg.wmask, s_reg.wdata};
                dpvdc_pkg::DPVDC_OFF_STATUS: s_next.prdata = {16'h0000, s_reg.rdata, 5'h00,
                    s_reg.ser_cnt != 10'h000, s_reg.sdir_host, s_reg.st != dpvdc_pkg::DPVDC_ST_IDLE};
                dpvdc_pkg::DPVDC_OFF_SERIAL: s_next.prdata = {s_reg.sp.sdq_o, 7'h00,
                    s_reg.sp.shift_output_gate_n, 6'h00, s_reg.ser_cnt};
                dpvdc_pkg::DPVDC_OFF_SDATA: s_next.prdata = {24'h000000, s_reg.sin};
                default: s_next.pslverr = 1'b1;
            endcase
        end
        if (psel_in && penable_in && s_reg.pready && pwrite_in) begin
            case (paddr_in)
                dpvdc_pkg::DPVDC_OFF_CTRL: begin
                    if (s_reg.st == dpvdc_pkg::DPVDC_ST_IDLE
                            && pwdata_in[dpvdc_pkg::DPVDC_CTRL_GO_BIT]) begin
                        s_next.op = dpvdc_pkg::dpvdc_op_e'(pwdata_in[3:0]);
                        s_next.masked = pwdata_in[dpvdc_pkg::DPVDC_CTRL_MASKED_BIT];
                        s_next.lo_en = pwdata_in[dpvdc_pkg::DPVDC_CTRL_LO_BIT];
                        s_next.hi_en = pwdata_in[dpvdc_pkg::DPVDC_CTRL_HI_BIT];
                        s_next.keep_opt = pwdata_in[dpvdc_pkg::DPVDC_CTRL_KEEP_BIT];
                        s_next.st = dpvdc_pkg::DPVDC_ST_ROW;
                        s_next.cnt = 8'h00;
                    end
                end
                dpvdc_pkg::DPVDC_OFF_ADDR: begin
                    s_next.row = pwdata_in[8:0];
                    s_next.col = pwdata_in[dpvdc_pkg::DPVDC_ADDR_COL_LSB +: 9];
                end
                dpvdc_pkg::DPVDC_OFF_WDATA: begin
                    s_next.wdata = pwdata_in[7:0];
                    s_next.wmask = pwdata_in[dpvdc_pkg::DPVDC_WDATA_MASK_LSB +: 8];
                end
                dpvdc_pkg::DPVDC_OFF_SERIAL: begin
                    s_next.ser_cnt = pwdata_in[9:0];
                    s_next.sp.shift_output_gate_n = pwdata_in[dpvdc_pkg::DPVDC_SER_GATE_BIT];
                    s_next.sp.sdq_o = pwdata_in[dpvdc_pkg::DPVDC_SER_DATA_LSB +: 8];
                end
                default: ;
            endcase
        end
        // Random-access sequencer
        case (s_reg.st)
            dpvdc_pkg::DPVDC_ST_IDLE: begin
                s_next.cnt = 8'h00;
                s_next.rp.addr = s_next.row;
                s_next.rp.transfer_output_enable_n = !is_xfer(s_next.op);
                s_next.rp.special_function_select = dsf_ras(s_next.op);
                s_next.rp.lower_write_mode_strobe_n = !wm_low(s_next.op, s_next.masked);
                s_next.rp.upper_write_mode_strobe_n = !wm_low(s_next.op, s_next.masked);
                // New mask rides on the data pins at the row strobe
                s_next.rp.dq_o = s_next.wmask;
                s_next.rp.dq_oe = s_next.masked && wm_low(s_next.op, s_next.masked)
                    && !is_cbr(s_next.op);
                if (s_next.st == dpvdc_pkg::DPVDC_ST_ROW) begin
                    s_next.rp.cas_n = !is_cbr(s_next.op);
                end
            end
            dpvdc_pkg::DPVDC_ST_ROW: if (ph_done) begin
                s_next.rp.ras_n = 1'b0;
                s_next.st = dpvdc_pkg::DPVDC_ST_RASL;
            end
            dpvdc_pkg::DPVDC_ST_RASL: if (ph_done) begin
                if (is_cbr(s_reg.op) || s_reg.op == dpvdc_pkg::DPVDC_OP_ROW_ONLY_REFRESH) begin
                    s_next.st = dpvdc_pkg::DPVDC_ST_PRE;
                end else begin
                    s_next.st = dpvdc_pkg::DPVDC_ST_COL;
                    s_next.rp.addr = s_reg.col;
                    s_next.rp.special_function_select = s_reg.op inside
                        {dpvdc_pkg::DPVDC_OP_BLOCK_FILL, dpvdc_pkg::DPVDC_OP_COLOR_LOAD};
                    s_next.rp.lower_write_mode_strobe_n = 1'b1;
                    s_next.rp.upper_write_mode_strobe_n = 1'b1;
                    s_next.rp.transfer_output_enable_n = is_wr(s_reg.op) || is_xfer(s_reg.op);
                    s_next.rp.dq_o = s_reg.wdata;
                    s_next.rp.dq_oe = is_wr(s_reg.op);
                end
            end
            dpvdc_pkg::DPVDC_ST_COL: if (ph_done) begin
                s_next.rp.cas_n = 1'b0;
                if (is_wr(s_reg.op)) begin
                    s_next.rp.lower_write_mode_strobe_n = !s_reg.lo_en;
                    s_next.rp.upper_write_mode_strobe_n = !s_reg.hi_en;
                end
                s_next.st = dpvdc_pkg::DPVDC_ST_CASL;
            end
            dpvdc_pkg::DPVDC_ST_CASL: if (ph_done) begin
                if (s_reg.op == dpvdc_pkg::DPVDC_OP_HIDDEN_REFRESH) begin
                    s_next.rp.ras_n = 1'b1;
                    s_next.st = dpvdc_pkg::DPVDC_ST_HIDE_UP;
                end else begin
                    s_next.st = dpvdc_pkg::DPVDC_ST_PRE;
                end
            end
            dpvdc_pkg::DPVDC_ST_HIDE_UP: if (ph_done) begin
                s_next.rp.ras_n = 1'b0;
                s_next.rp.special_function_select = s_reg.keep_opt;
                s_next.st = dpvdc_pkg::DPVDC_ST_HIDE_DN;
            end
            dpvdc_pkg::DPVDC_ST_HIDE_DN: if (ph_done) begin
                s_next.st = dpvdc_pkg::DPVDC_ST_PRE;
            end
            dpvdc_pkg::DPVDC_ST_PRE: begin
                s_next.rp.ras_n = 1'b1;
                s_next.rp.cas_n = 1'b1;
                s_next.rp.lower_write_mode_strobe_n = 1'b1;
                s_next.rp.upper_write_mode_strobe_n = 1'b1;
                s_next.rp.transfer_output_enable_n = 1'b1;
                s_next.rp.special_function_select = 1'b0;
                s_next.rp.dq_oe = 1'b0;
                // Sync chain lags two cycles: its last stage still holds the strobed read data
                if (s_reg.cnt == 8'h00 && s_reg.op == dpvdc_pkg::DPVDC_OP_READ) begin
                    s_next.rdata = s_reg.dq_s2;
                end
                if (ph_done) begin
                    s_next.st = dpvdc_pkg::DPVDC_ST_IDLE;
                    // Mirror the device's serial direction
                    if (s_reg.op == dpvdc_pkg::DPVDC_OP_FULL_READ_LOAD) begin
                        s_next.sdir_host = 1'b0;
                    end else if (s_reg.op == dpvdc_pkg::DPVDC_OP_ARRAY_LOAD) begin
                        s_next.sdir_host = 1'b1;
                    end
                end
            end
            default: s_next.st = dpvdc_pkg::DPVDC_ST_IDLE;
        endcase
        // Serial clock generator, held still while a transfer runs
        s_next.sp.sdq_oe = s_reg.sdir_host;
        if (s_reg.ser_cnt != 10'h000 && !(is_xfer(s_reg.op)
                && s_reg.st != dpvdc_pkg::DPVDC_ST_IDLE)) begin
            s_next.ser_half = (s_reg.ser_half == SH_LAST) ? 8'h00 : s_reg.ser_half + 8'h01;
            if (s_reg.ser_half == SH_LAST) begin
                s_next.sp.serial_clock = !s_reg.sp.serial_clock;
                if (!s_reg.sp.serial_clock) begin
                    s_next.ser_cnt = s_reg.ser_cnt - 10'h001;
                    s_next.sin = s_reg.sq_s2;
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
            s_reg.st <= dpvdc_pkg::DPVDC_ST_IDLE;
            s_reg.op <= dpvdc_pkg::DPVDC_OP_NONE;
            s_reg.rp <= '{ras_n: 1'b1, cas_n: 1'b1, addr: 9'h000,
                lower_write_mode_strobe_n: 1'b1, upper_write_mode_strobe_n: 1'b1,
                transfer_output_enable_n: 1'b1, special_function_select: 1'b0,
                dq_o: 8'h00, dq_oe: 1'b0};
            s_reg.sp.shift_output_gate_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_out = s_reg.prdata;
    assign pready_out = s_reg.pready;
    assign pslverr_out = s_reg.pslverr;
    assign ram_pins_out = s_reg.rp;
    assign ser_pins_out = s_reg.sp;

    property p_row_at_ras;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.ras_n) && ram_pins_out.cas_n |-> ram_pins_out.addr == s_reg.row;
    endproperty
    a_row_at_ras: assert property (p_row_at_ras) else $error("row address wrong");

    property p_col_at_cas;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.cas_n) && !ram_pins_out.ras_n |-> ram_pins_out.addr == s_reg.col;
    endproperty
    a_col_at_cas: assert property (p_col_at_cas) else $error("column address wrong");

    property p_dsf_at_ras;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.ras_n) && s_reg.st == dpvdc_pkg::DPVDC_ST_RASL
            |-> ram_pins_out.special_function_select == dsf_ras(s_reg.op);
    endproperty
    a_dsf_at_ras: assert property (p_dsf_at_ras) else $error("select wrong at row");

    property p_cbr_stop;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.ras_n) && s_reg.op == dpvdc_pkg::DPVDC_OP_REFRESH_STOP_SET
            |-> !ram_pins_out.cas_n && !ram_pins_out.lower_write_mode_strobe_n
            && ram_pins_out.special_function_select && ram_pins_out.addr == s_reg.row;
    endproperty
    a_cbr_stop: assert property (p_cbr_stop) else $error("stop set pins wrong");

    property p_cbr_order;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.ras_n) && !ram_pins_out.cas_n
            |-> is_cbr(s_reg.op) || s_reg.op == dpvdc_pkg::DPVDC_OP_HIDDEN_REFRESH;
    endproperty
    a_cbr_order: assert property (p_cbr_order) else $error("column strobe early");

    property p_xfer_toe;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(ram_pins_out.ras_n) && s_reg.st == dpvdc_pkg::DPVDC_ST_RASL
            |-> ram_pins_out.transfer_output_enable_n == !is_xfer(s_reg.op);
    endproperty
    a_xfer_toe: assert property (p_xfer_toe) else $error("transfer enable wrong");

    property p_serial_still;
        @(posedge mclk_in) disable iff (!rstn_in)
        is_xfer(s_reg.op) && s_reg.st != dpvdc_pkg::DPVDC_ST_IDLE
            |=> $stable(ser_pins_out.serial_clock);
    endproperty
    a_serial_still: assert property (p_serial_still) else $error("serial clock moved");

    property p_dir_after_load;
        @(posedge mclk_in) disable iff (!rstn_in)
        s_reg.st == dpvdc_pkg::DPVDC_ST_PRE && ph_done
            && s_reg.op == dpvdc_pkg::DPVDC_OP_ARRAY_LOAD |=> ##1 ser_pins_out.sdq_oe;
    endproperty
    a_dir_after_load: assert property (p_dir_after_load) else $error("serial dir wrong");

    property p_cycle_ends;
        @(posedge mclk_in) disable iff (!rstn_in)
        $rose(s_reg.st == dpvdc_pkg::DPVDC_ST_ROW)
            |-> ##[1:200] s_reg.st == dpvdc_pkg::DPVDC_ST_IDLE && ram_pins_out.ras_n;
    endproperty
    a_cycle_ends: assert property (p_cycle_ends) else $error("cycle did not end");
endmodule

// *** dpvdc_vram_model.sv ***
`timescale 1ns/1ps
module dpvdc_vram_model (
    input wire dpvdc_pkg::dpvdc_ram_pins_s ram_in,
    input wire dpvdc_pkg::dpvdc_ser_pins_s ser_in,
    output logic [7:0] ram_lvl_out,
    output logic [7:0] ser_lvl_out
);
    logic [7:0] mem [0:511];
    logic [8:0] col, stop, ptr;
    logic [7:0] mask, last_r, last_s;
    logic masked, xfer, cbr, dir_out, stop_ok, rd, sd;
    initial {ptr, last_r, last_s, dir_out, stop_ok, xfer, cbr, col} = '0;
    always @(negedge ram_in.ras_n) begin
        cbr = !ram_in.cas_n;
        xfer = !cbr && !ram_in.transfer_output_enable_n;
        masked = !ram_in.lower_write_mode_strobe_n;
        mask = ram_lvl_out;
        if (cbr && !ram_in.special_function_select) stop_ok = 1'b0;
        if (cbr && ram_in.special_function_select && masked) begin
            stop = ram_in.addr;
            stop_ok = 1'b1;
        end
        if (xfer && !ram_in.special_function_select) dir_out = !masked;
    end
    always @(negedge ram_in.cas_n) begin
        col = ram_in.addr;
        if (xfer) ptr = ram_in.addr;
        else if (!ram_in.ras_n && ram_in.dq_oe) begin
            for (int i = 0; i < 8; i++) begin
                if ((i < 4 ? !ram_in.lower_write_mode_strobe_n
                        : !ram_in.upper_write_mode_strobe_n) && (!masked || mask[i])) begin
                    mem[col][i] = ram_lvl_out[i];
                end
            end
        end
    end
    assign rd = !ram_in.ras_n && !ram_in.cas_n && !cbr && !xfer && !ram_in.dq_oe
        && ram_in.lower_write_mode_strobe_n;
    assign sd = dir_out && !ser_in.shift_output_gate_n && !ser_in.sdq_oe;
    assign ram_lvl_out = ram_in.dq_oe ? ram_in.dq_o : (rd ? mem[col] : ~last_r);
    assign ser_lvl_out = ser_in.sdq_oe ? ser_in.sdq_o : (sd ? 8'h30 + ptr[7:0] : ~last_s);
    always @(ram_lvl_out) if (ram_in.dq_oe || rd) last_r = ram_lvl_out;
    always @(ser_lvl_out) if (ser_in.sdq_oe || sd) last_s = ser_lvl_out;
    always @(posedge ser_in.serial_clock) ptr = ptr + 9'h001;
endmodule

// *** tb_dpvdc_ctrl.sv ***
`timescale 1ns/1ps
module tb_dpvdc_ctrl;
    logic mclk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, rerr;
    logic [7:0] paddr_in, ram_lvl, ser_lvl;
    logic [31:0] pwdata_in, prdata_out, rdata;
    dpvdc_pkg::dpvdc_ram_pins_s ram_pins;
    dpvdc_pkg::dpvdc_ser_pins_s ser_pins;
    logic [3:0] at_ras;
    int fails = 0;
    int cmp_count = 0;
    logic [1:0] ref_exp [0:4] = '{2'b00, 2'b10, 2'b11, 2'b11, 2'b11};
    logic [3:0] wfl [0:2] = '{4'b0110, 4'b0111, 4'b0010};
    logic [15:0] wdt [0:2] = '{16'h005a, 16'h0fff, 16'h0000};
    logic [7:0] wexp [0:2] = '{8'h5a, 8'h5f, 8'h50};
    dpvdc_ctrl u_dpvdc_ctrl (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .ram_pins_out(ram_pins), .ram_data_pins_in(ram_lvl),
        .ser_pins_out(ser_pins), .serial_data_pins_in(ser_lvl));
    dpvdc_vram_model u_dpvdc_vram_model (.ram_in(ram_pins), .ser_in(ser_pins),
        .ram_lvl_out(ram_lvl), .ser_lvl_out(ser_lvl));
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    always @(negedge ram_pins.ras_n) at_ras = {!ram_pins.cas_n,
        ram_pins.special_function_select, ram_pins.lower_write_mode_strobe_n,
        ram_pins.transfer_output_enable_n};
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
        end while (pready_out !== 1'b1);
        rdata = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, dpvdc_pkg::DPVDC_OFF_STATUS, 32'h0);
            n++;
        end while (rdata[b] !== 1'b0 && n < 100);
        cmp(32'(rdata[b]), 32'h0, "busy stuck");
    endtask
    task automatic op(input logic [3:0] code, input logic [3:0] fl, input logic [8:0] row,
            input logic [8:0] col, input logic [15:0] wd);
        apb(1'b1, dpvdc_pkg::DPVDC_OFF_ADDR, {7'h00, col, 7'h00, row});
        apb(1'b1, dpvdc_pkg::DPVDC_OFF_WDATA, {16'h0000, wd});
        apb(1'b1, dpvdc_pkg::DPVDC_OFF_CTRL, {23'h000000, 1'b1, fl, code});
        poll(0);
    endtask
    task automatic ser_run(input logic gate, input logic [9:0] cnt);
        apb(1'b1, dpvdc_pkg::DPVDC_OFF_SERIAL, {15'h0000, gate, 6'h00, cnt});
        poll(2);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        rstn_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        cmp(32'({ram_pins.ras_n, ram_pins.cas_n, ser_pins.shift_output_gate_n}), 32'h7, "idle");
        apb(1'b0, dpvdc_pkg::DPVDC_OFF_STATUS, 32'h0);
        cmp(rdata, 32'h0, "status after reset");
        apb(1'b0, 8'h18, 32'h0);
        cmp({rdata[30:0], rerr}, 32'h1, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            op(4'h1, wfl[i], 9'h001, 9'h003, wdt[i]);
            op(4'h0, 4'b0110, 9'h001, 9'h003, 16'h0000);
            cmp(32'(rdata[15:8]), 32'(wexp[i]), "ram write");
        end
        $display("test ram access done");
        for (int i = 0; i < 5; i++) begin
            op(4'ha + 4'(i), 4'b1000, 9'h0f0, 9'h000, 16'h0000);
            cmp(32'(at_ras[3:2]), 32'(ref_exp[i]), "refresh strobes");
            if (i == 2 || i == 3) cmp(32'(at_ras[1]), 32'(i == 3), "refresh wm");
        end
        $display("test refresh done");
        op(4'h6, 4'b0110, 9'h002, 9'h004, 16'h0000);
        cmp(32'({at_ras[0], rdata[1]}), 32'h0, "read load");
        ser_run(1'b0, 10'h002);
        apb(1'b0, dpvdc_pkg::DPVDC_OFF_SDATA, 32'h0);
        cmp(32'(rdata[7:0]), 32'h35, "serial data");
        ser_run(1'b1, 10'h001);
        ser_run(1'b0, 10'h002);
        apb(1'b0, dpvdc_pkg::DPVDC_OFF_SDATA, 32'h0);
        cmp(32'(rdata[7:0]), 32'h38, "gated pointer");
        op(4'h8, 4'b0111, 9'h002, 9'h000, 16'hff00);
        cmp(32'({rdata[1], ser_pins.sdq_oe}), 32'h3, "array load dir");
        op(4'h7, 4'b0110, 9'h002, 9'h100, 16'h0000);
        cmp(32'(rdata[1]), 32'h1, "split keeps dir");
        $display("test transfers done");
        final_report();
    end
endmodule
